//--- tsb_pkg.sv
// Summary of operation
// - SDA held low longer than the bus-stuck interval (75 to 325 ms) returns the serial interface to idle and releases SDA.
// - After a bus-fault timeout the interface ignores the bus until a fresh start condition arrives.
// - In shutdown the bus-fault timeout is disabled.
// - A bus access aborts a running conversion, and a new one starts once the access is over.
// - The master can read the temperature at any time and gets the last completed result.
// - Each conversion yields a 9-bit result that the comparator checks and the master reads.
// - The comparator checks a software-chosen run of results against an over-temperature and a hysteresis limit.
// - The comparator drives the over-temperature pin, whose mode and polarity software sets.
// - SDA and SCL are low-pass filtered for bus-idle and timeout detection; the serial interface samples the raw pins.
// - The output asserts only after the configured count (up to six) of consecutive out-of-limit results.
// - In comparator mode the output asserts above the over-temperature limit and clears below the hysteresis limit.
// - In interrupt mode the output stays asserted until a bus read or until shutdown.
// - The slave address is 1001 followed by the three address-select pins.
package tsb_pkg;

  localparam longint unsigned TSB_CLK_HZ        = 64'h17d7840;
  localparam longint unsigned TSB_TIMEOUT_MIN_MS = 64'h4b;
  localparam longint unsigned TSB_TIMEOUT_MAX_MS = 64'h145;
  localparam longint unsigned TSB_CONV_MS        = 64'h64;
  localparam longint unsigned TSB_IDLE_NS        = 64'h3e8;
  localparam longint unsigned TSB_MS_PER_S       = 64'h3e8;
  localparam longint unsigned TSB_NS_PER_S       = 64'h3b9aca00;

  // Least times round up to whole cycles
  localparam longint unsigned TSB_TIMEOUT_CYC =
    (TSB_TIMEOUT_MIN_MS * TSB_CLK_HZ + TSB_MS_PER_S - 64'h1) / TSB_MS_PER_S;
  localparam longint unsigned TSB_CONV_CYC =
    (TSB_CONV_MS * TSB_CLK_HZ + TSB_MS_PER_S - 64'h1) / TSB_MS_PER_S;
  localparam longint unsigned TSB_IDLE_CYC =
    (TSB_IDLE_NS * TSB_CLK_HZ + TSB_NS_PER_S - 64'h1) / TSB_NS_PER_S;

  localparam int TSB_CNT_W  = 22;
  localparam int TSB_IDLE_W = 6;
  localparam int TSB_FILT_N = 3;
  localparam int TSB_LINES  = 2;
  localparam int TSB_SCL    = 0;
  localparam int TSB_SDA    = 1;

  localparam logic [3:0] TSB_ADDR_HI    = 4'h9;
  localparam logic [2:0] TSB_QUEUE_MIN  = 3'h1;
  localparam logic [2:0] TSB_QUEUE_MAX  = 3'h6;
  localparam logic [2:0] TSB_BIT_LAST   = 3'h7;
  localparam logic [8:0] TSB_TEMP_RST   = 9'h000;
  localparam logic [1:0] TSB_LINES_RST  = 2'h3;
  localparam logic [6:0] TSB_PAD_LO     = 7'h00;

  typedef logic signed [8:0] tsb_temp_t;

  typedef enum logic [6:0] {
    LK_IDLE  = 7'h01,
    LK_ADDR  = 7'h02,
    LK_ACK_A = 7'h04,
    LK_WRITE = 7'h08,
    LK_ACK_W = 7'h10,
    LK_READ  = 7'h20,
    LK_ACK_R = 7'h40
  } tsb_link_st_t;

  typedef struct packed {
    logic [TSB_LINES-1:0]                 sync1;
    logic [TSB_LINES-1:0]                 sync2;
    logic [TSB_LINES-1:0][TSB_FILT_N-1:0] hist;
    logic [TSB_LINES-1:0]                 filt;
    logic [TSB_IDLE_W-1:0]                idle_cnt;
    logic                                 bus_idle;
    logic [TSB_CNT_W-1:0]                 to_cnt;
    logic                                 timeout;
    logic [TSB_CNT_W-1:0]                 conv_cnt;
    tsb_temp_t                            temp;
    logic [2:0]                           over_cnt;
    logic [2:0]                           under_cnt;
    logic                                 os_active;
    logic                                 look_under;
    logic [2:0]                           rd_sync;
    logic                                 os_oe;
  } tsb_core_t;

  typedef struct packed {
    tsb_link_st_t state;
    logic [2:0]   bitcnt;
    logic [7:0]   shift;
    logic         rw;
    logic         byte_idx;
    logic         sda_oe;
    logic         rd_tgl;
    logic [2:0]   ap1;
    logic [2:0]   ap2;
  } tsb_link_t;

endpackage

//--- tsb_core.sv
`timescale 1ns/1ps
module tsb_core
  import tsb_pkg::*;
#(
  parameter longint unsigned TIMEOUT_CYCLES = TSB_TIMEOUT_CYC,
  parameter longint unsigned CONV_CYCLES    = TSB_CONV_CYC
)
(
  // Clocks and reset
  input  wire logic       core_clk_in,
  input  wire logic       scl_clk_in,
  input  wire logic       reset_n_in,
  // Bus pins
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic [2:0] address_select_pins_in,
  // Over-temperature pin, open drain
  output logic            os_out,
  output logic            os_oe_out,
  // Sensor and configuration
  input  wire logic [8:0] adc_result_in,
  input  wire logic       shutdown_in,
  input  wire logic       interrupt_mode_in,
  input  wire logic       os_active_high_in,
  input  wire logic [2:0] fault_queue_in,
  input  wire logic [8:0] overtemp_limit_in,
  input  wire logic [8:0] hysteresis_limit_in,
  // Status
  output logic [8:0]      temp_out,
  output logic            timeout_out
);
  localparam logic [TSB_CNT_W-1:0] TO_LAST =
    TSB_CNT_W'(TIMEOUT_CYCLES - 64'h1);
  localparam logic [TSB_CNT_W-1:0] CONV_LAST =
    TSB_CNT_W'(CONV_CYCLES - 64'h1);
  localparam logic [TSB_IDLE_W-1:0] IDLE_LAST =
    TSB_IDLE_W'(TSB_IDLE_CYC - 64'h1);
  tsb_core_t c_r;
  tsb_core_t c_nxt;
  tsb_link_t l_r;
  tsb_link_t l_nxt;
  logic      sda_rise_r;
  logic      link_rst_n;
  logic [TSB_LINES-1:0] pins;
  logic [2:0]           queue;
  logic                 over;
  logic                 under;
  logic                 over_hit;
  logic                 under_hit;
  logic                 rd_evt;
  assign pins = {sda_in, scl_clk_in};
  // Fault queue length clamped to 1..6
  always_comb
  begin
    if (fault_queue_in < TSB_QUEUE_MIN)
      queue = TSB_QUEUE_MIN;
    else if (fault_queue_in > TSB_QUEUE_MAX)
      queue = TSB_QUEUE_MAX;
    else
      queue = fault_queue_in;
  end
  assign over      = $signed(adc_result_in) > $signed(overtemp_limit_in);
  assign under     = $signed(adc_result_in) < $signed(hysteresis_limit_in);
  assign over_hit  = over && ((c_r.over_cnt + 3'h1) >= queue);
  assign under_hit = under && ((c_r.under_cnt + 3'h1) >= queue);
  assign rd_evt    = c_r.rd_sync[2] ^ c_r.rd_sync[1];
  always_comb
  begin
    c_nxt         = c_r;
    c_nxt.sync1   = pins;
    c_nxt.sync2   = c_r.sync1;
    c_nxt.rd_sync = {c_r.rd_sync[1:0], l_r.rd_tgl};
    for (int i = 0; i < TSB_LINES; i++)
    begin
      c_nxt.hist[i] = {c_r.hist[i][TSB_FILT_N-2:0], c_r.sync2[i]};
      if (&c_r.hist[i])
        c_nxt.filt[i] = 1'b1;
      else if (~|c_r.hist[i])
        c_nxt.filt[i] = 1'b0;
    end
    // Bus counts as idle once both lines stay high for a while
    if (!(c_r.filt[TSB_SCL] && c_r.filt[TSB_SDA]))
    begin
      c_nxt.idle_cnt = '0;
      c_nxt.bus_idle = 1'b0;
    end
    else if (c_r.idle_cnt == IDLE_LAST)
      c_nxt.bus_idle = 1'b1;
    else
      c_nxt.idle_cnt = c_r.idle_cnt + 1'b1;
    if (shutdown_in || c_r.filt[TSB_SDA])
    begin
      c_nxt.to_cnt  = '0;
      c_nxt.timeout = 1'b0;
    end
    else if (c_r.to_cnt == TO_LAST)
      c_nxt.timeout = 1'b1;
    else
      c_nxt.to_cnt = c_r.to_cnt + 1'b1;
    // read or shutdown clears interrupt mode output
    if (interrupt_mode_in && (rd_evt || shutdown_in))
      c_nxt.os_active = 1'b0;
    if (shutdown_in || !c_r.bus_idle)
      c_nxt.conv_cnt = '0;
    else if (c_r.conv_cnt != CONV_LAST)
      c_nxt.conv_cnt = c_r.conv_cnt + 1'b1;
    else
    begin
      c_nxt.conv_cnt  = '0;
      c_nxt.temp      = adc_result_in;
      c_nxt.over_cnt  = over ? (over_hit ? queue : c_r.over_cnt + 3'h1)
                             : '0;
      c_nxt.under_cnt = under ? (under_hit ? queue : c_r.under_cnt + 3'h1)
                              : '0;
      if (!interrupt_mode_in)
      begin
        if (over_hit)
          c_nxt.os_active = 1'b1;
        else if (under_hit)
          c_nxt.os_active = 1'b0;
      end
      // Set wins over a read clear in the same cycle
      else if (!c_r.look_under && over_hit)
      begin
        c_nxt.os_active  = 1'b1;
        c_nxt.look_under = 1'b1;
      end
      else if (c_r.look_under && under_hit)
      begin
        c_nxt.os_active  = 1'b1;
        c_nxt.look_under = 1'b0;
      end
    end

    // polarity select on the open-drain pin
    c_nxt.os_oe = c_nxt.os_active ^ os_active_high_in;
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      c_r          <= '0;
      c_r.sync1    <= TSB_LINES_RST;
      c_r.sync2    <= TSB_LINES_RST;
      c_r.hist     <= '1;
      c_r.filt     <= TSB_LINES_RST;
      c_r.bus_idle <= 1'b1;
      c_r.temp     <= TSB_TEMP_RST;
    end
    else
      c_r <= c_nxt;
  end
  // Link side: SCL domain, held in reset by a bus-fault timeout
  assign link_rst_n = reset_n_in && !c_r.timeout;
  function automatic logic [7:0] read_byte(input logic idx,
                                           input tsb_temp_t t);
    // temperature is stable while the bus is busy
    read_byte = idx ? {t[0], TSB_PAD_LO} : t[8:1];
  endfunction
  always_ff @(posedge scl_clk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
      sda_rise_r <= 1'b1;
    else
      sda_rise_r <= sda_in;
  end
  always_comb
  begin
    l_nxt     = l_r;
    l_nxt.ap1 = address_select_pins_in;
    l_nxt.ap2 = l_r.ap1;
    if (sda_rise_r && !sda_in)
    begin
      l_nxt.state  = LK_ADDR;
      l_nxt.bitcnt = '0;
      l_nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (l_r.state)
        LK_ADDR:
        begin
          l_nxt.shift  = {l_r.shift[6:0], sda_rise_r};
          l_nxt.bitcnt = l_r.bitcnt + 1'b1;
          if (l_r.bitcnt == TSB_BIT_LAST)
          begin
            if (l_r.shift[6:0] == {TSB_ADDR_HI, l_r.ap2})
            begin
              l_nxt.state    = LK_ACK_A;
              l_nxt.rw       = sda_rise_r;
              l_nxt.sda_oe   = 1'b1;
              l_nxt.byte_idx = 1'b0;
              l_nxt.rd_tgl   = l_r.rd_tgl ^ sda_rise_r;
            end
            else
              l_nxt.state = LK_IDLE;
          end
        end
        LK_ACK_A:
        begin
          l_nxt.bitcnt = '0;
          if (l_r.rw)
          begin
            l_nxt.state  = LK_READ;
            l_nxt.shift  = read_byte(1'b0, c_r.temp);
            l_nxt.sda_oe = !l_nxt.shift[7];
          end
          else
          begin
            l_nxt.state  = LK_WRITE;
            l_nxt.sda_oe = 1'b0;
          end
        end
        LK_WRITE:
        begin
          l_nxt.shift  = {l_r.shift[6:0], sda_rise_r};
          l_nxt.bitcnt = l_r.bitcnt + 1'b1;
          if (l_r.bitcnt == TSB_BIT_LAST)
          begin
            l_nxt.state  = LK_ACK_W;
            l_nxt.sda_oe = 1'b1;
          end
        end
        LK_ACK_W:
        begin
          l_nxt.state  = LK_WRITE;
          l_nxt.sda_oe = 1'b0;
          l_nxt.bitcnt = '0;
        end
        LK_READ:
        begin
          if (l_r.bitcnt == TSB_BIT_LAST)
          begin
            l_nxt.state  = LK_ACK_R;
            l_nxt.sda_oe = 1'b0;
          end
          else
          begin
            l_nxt.shift  = {l_r.shift[6:0], 1'b0};
            l_nxt.sda_oe = !l_r.shift[6];
            l_nxt.bitcnt = l_r.bitcnt + 1'b1;
          end
        end
        LK_ACK_R:
        begin
          l_nxt.bitcnt = '0;
          if (!sda_rise_r)
          begin
            l_nxt.state    = LK_READ;
            l_nxt.byte_idx = !l_r.byte_idx;
            l_nxt.shift    = read_byte(!l_r.byte_idx, c_r.temp);
            l_nxt.sda_oe   = !l_nxt.shift[7];
          end
          else
            l_nxt.state = LK_IDLE;
        end
        default:
          l_nxt.state = LK_IDLE;
      endcase
    end
  end

  always_ff @(negedge scl_clk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      l_r       <= '0;
      l_r.state <= LK_IDLE;
    end
    else
      l_r <= l_nxt;
  end
  assign sda_out     = l_r.shift[0] & 1'b0;
  assign sda_oe_out  = l_r.sda_oe;
  assign os_out      = c_r.os_oe & 1'b0;
  assign os_oe_out   = c_r.os_oe;
  assign temp_out    = c_r.temp;
  assign timeout_out = c_r.timeout;
endmodule

//--- tsb_core_monitor.sv
`timescale 1ns/1ps
module tsb_core_monitor
  import tsb_pkg::*;
#(
  parameter longint unsigned TIMEOUT_CYCLES = TSB_TIMEOUT_CYC
)
(
  // Watched ports
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  input wire logic       sda_in,
  input wire logic       sda_oe_out,
  input wire logic       os_oe_out,
  input wire logic [8:0] adc_result_in,
  input wire logic       shutdown_in,
  input wire logic       interrupt_mode_in,
  input wire logic       os_active_high_in,
  input wire logic [8:0] overtemp_limit_in,
  input wire logic [8:0] temp_out,
  input wire logic       timeout_out
);
  logic [31:0] low_r;
  logic        act;
  assign act = os_oe_out ^ os_active_high_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Length of the present SDA low stretch outside shutdown
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      low_r <= '0;
    else if (sda_in || shutdown_in)
      low_r <= '0;
    else if (low_r != '1)
      low_r <= low_r + 32'h1;
  property p_temp;
    $changed(temp_out) |-> temp_out == $past(adc_result_in);
  endproperty
  a_temp: assert property (p_temp) else $error("bad result");
  property p_to_oe;
    timeout_out |-> !sda_oe_out;
  endproperty
  a_to_oe: assert property (p_to_oe) else $error("sda held");
  property p_to_min;
    $rose(timeout_out) |-> low_r >= TIMEOUT_CYCLES;
  endproperty
  a_to_min: assert property (p_to_min) else $error("early");
  property p_to_max;
    low_r == TIMEOUT_CYCLES + 16 |-> timeout_out;
  endproperty
  a_to_max: assert property (p_to_max) else $error("late");
  property p_to_clr;
    timeout_out && $rose(sda_in) |-> ##[1:16] !timeout_out;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("stuck");
  property p_sd_to;
    shutdown_in [*8] |-> !$rose(timeout_out);
  endproperty
  a_sd_to: assert property (p_sd_to) else $error("sd timeout");
  property p_cmp;
    !interrupt_mode_in && !shutdown_in && $stable(os_active_high_in)
      && $rose(act) |-> $signed(temp_out) > $signed(overtemp_limit_in);
  endproperty
  a_cmp: assert property (p_cmp) else $error("bad trip");
  property p_sd_int;
    (interrupt_mode_in && shutdown_in) [*4] |-> !act;
  endproperty
  a_sd_int: assert property (p_sd_int) else $error("not cleared");
  cover property ($rose(timeout_out));
  cover property ($rose(act));
  cover property ($changed(temp_out));
endmodule

bind tsb_core tsb_core_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .sda_in(sda_in),
  .sda_oe_out(sda_oe_out), .os_oe_out(os_oe_out),
  .adc_result_in(adc_result_in), .shutdown_in(shutdown_in),
  .interrupt_mode_in(interrupt_mode_in),
  .os_active_high_in(os_active_high_in),
  .overtemp_limit_in(overtemp_limit_in), .temp_out(temp_out),
  .timeout_out(timeout_out));

//--- tsb_i2c_master.sv
`timescale 1ns/1ps
module tsb_i2c_master
(
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Rise with SDA high, then SDA falls while SCL is high
  task automatic start();
    #13 scl_out = 1'b0;
    sda_low_out = 1'b0;
    #40 scl_out = 1'b1;
    #20 sda_low_out = 1'b1;
    #400;
  endtask
  // Byte then acknowledge bit; a one releases SDA for the far end
  task automatic xfer(input logic [7:0] b, input logic ab,
                      output logic [7:0] r, output logic ar);
    logic [8:0] d;
    d = {b, ab};
    for (int i = 8; i >= 0; i--)
    begin
      scl_out = 1'b0;
      #20 sda_low_out = !d[i];
      #20 scl_out = 1'b1;
      #20 d[i] = sda_in;
      #20;
    end
    r = d[8:1];
    ar = d[0];
  endtask
  task automatic stop();
    scl_out = 1'b0;
    #20 sda_low_out = 1'b1;
    #20 scl_out = 1'b1;
    #20 sda_low_out = 1'b0;
  endtask
  // Deliberate bus fault: SDA held low, clock still
  task automatic hold(input int ns);
    sda_low_out = 1'b1;
    #(ns);
    sda_low_out = 1'b0;
  endtask
endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb
  import tsb_pkg::*;
;
  localparam int TO = 200;
  localparam int CV = 300;
  logic       clk, rst_n, scl, sda, mlow, sd, im, hi, ak;
  logic       sda_o, sda_oe, os_o, os_oe, to;
  logic [2:0] fq, ap;
  logic [8:0] adc, lim, hy, temp, lt;
  logic [7:0] b0, b1;
  int         n_fail, n_tests, cyc, nq, w;
  assign sda = !(mlow || (sda_oe && !sda_o));
  tsb_core #(.TIMEOUT_CYCLES(TO), .CONV_CYCLES(CV)) u_dut (
    .core_clk_in(clk), .scl_clk_in(scl), .reset_n_in(rst_n), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .address_select_pins_in(ap),
    .os_out(os_o), .os_oe_out(os_oe), .adc_result_in(adc),
    .shutdown_in(sd), .interrupt_mode_in(im), .os_active_high_in(hi),
    .fault_queue_in(fq), .overtemp_limit_in(lim),
    .hysteresis_limit_in(hy), .temp_out(temp), .timeout_out(to));
  tsb_i2c_master u_mst (.sda_in(sda), .scl_out(scl), .sda_low_out(mlow));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic eoe(input logic a);
    return a ^ hi;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conv(input logic [8:0] v);
    adc = v;
    w = 0;
    while (temp !== v && w < 2000)
    begin
      tick(1);
      w++;
    end
    lt = v;
    chk(temp, v);
  endtask
  task automatic q(input logic [8:0] base, input int dir,
                   input logic a0, input logic a1);
    for (int i = 1; i <= nq; i++)
    begin
      conv(base + 9'(dir * i));
      chk(os_oe, eoe(i == nq ? a1 : a0));
    end
  endtask
  task automatic rd(input logic [2:0] a);
    logic [7:0] x;
    u_mst.start();
    u_mst.xfer({4'h9, a, 1'b1}, 1'b1, x, ak);
    if (ak === 1'b0)
    begin
      u_mst.xfer(8'hff, 1'b0, b0, x[0]);
      u_mst.xfer(8'hff, 1'b1, b1, x[0]);
    end
    u_mst.stop();
    tick(1);
  endtask
  initial
  begin
    void'($urandom(32'h1ce1));
    rst_n = 1'b0;
    adc = 9'h000;
    sd = 1'b0;
    im = 1'b0;
    hi = 1'($urandom);
    ap = 3'($urandom);
    nq = $urandom_range(1, 6);
    // Queue ends drive the codes that clamp to one and six
    fq = (nq == 1) ? 3'h0 : ((nq == 6) ? 3'h7 : 3'(nq));
    lim = 9'h0a0 + 9'($urandom_range(0, 31));
    hy = lim - 9'h010;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(2);
    chk(temp, 9'h000);
    chk(to, 1'b0);
    chk(os_oe, eoe(1'b0));
    chk(os_o, 1'b0);
    q(lim, 1, 1'b0, 1'b1);
    rd(ap);
    chk(ak, 1'b0);
    chk(b0, lt[8:1]);
    chk(b1, {lt[0], 7'h00});
    chk(os_oe, eoe(1'b1));
    rd(ap ^ 3'h1);
    chk(ak, 1'b1);
    q(hy, -1, 1'b1, 1'b0);
    conv(9'h005);
    adc = 9'h007;
    tick(CV / 2);
    rd(ap);
    chk(temp, 9'h005);
    chk(b0, 8'h02);
    conv(9'h007);
    chk(w >= CV && w <= CV + 50, 1'b1);
    // Two-sample SDA glitch must not abort the running conversion
    u_mst.hold(80);
    conv(9'h009);
    chk(w < CV, 1'b1);
    im = 1'b1;
    q(lim, 1, 1'b0, 1'b1);
    rd(ap);
    tick(8);
    chk(os_oe, eoe(1'b0));
    q(hy, -1, 1'b0, 1'b1);
    sd = 1'b1;
    tick(8);
    chk(os_oe, eoe(1'b0));
    u_mst.hold((TO + 60) * 40);
    tick(1);
    chk(to, 1'b0);
    sd = 1'b0;
    im = 1'b0;
    tick(2);
    u_mst.hold((TO + 60) * 40);
    chk(to, 1'b1);
    tick(30);
    chk(to, 1'b0);
    rd(ap);
    chk(ak, 1'b0);
    chk(b0, lt[8:1]);
    end_sim();
  end
endmodule
